// >>> hdl/bcfg_device.sv
// Device end: start-up configuration sequencer plus host command mailbox.
// Assumes memory probe signals come from logic on i_clk_sys; strap pins are asynchronous.
//
// Design decision made here: the word-level register bus port (bcfg_if).
`timescale 1ns/10ps
module bcfg_device
   import bcfg_pkg::*;
#(
   parameter int POOL_WORDS = 8,
   parameter int DETECT_CYCLES = 16,
   parameter int LOAD_CYCLES = 1024
)
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Register bus from the host.
   bcfg_if.dev bus,
   // Memory probe and record processing status.
   input wire logic i_mem_present,
   input wire logic i_mem_has_records,
   input wire logic i_mem_rec_done,
   input wire logic [1:0] i_mem_rec_jump,
   // Strap pins sampled during boot.
   input wire logic i_memory_serial_in_strap,
   input wire logic i_frame_valid,
   input wire logic i_line_valid,
   input wire logic i_low_output_bit0_pin,
   input wire logic i_low_output_bit1_pin,
   // Boot and command status.
   output bcfg_pkg::bcfg_boot_type o_boot_state,
   output logic [3:0] o_auto_setting,
   output logic o_apply_strobe,
   output logic o_streaming,
   output logic o_doorbell_irq,
   output logic o_load_busy
);
   import bcfg_pkg::*;

   // The pool must not wrap past the top address, and detection must outlast the strap filter.
   if (POOL_WORDS < 1 || POOL_WORDS > 1023 || DETECT_CYCLES < 5 || DETECT_CYCLES > 65535
       || LOAD_CYCLES < 2 || LOAD_CYCLES > 65535)
   begin : g_bad_param
      $error("bcfg_device: unsupported parameter value");
   end

   localparam int PW = (POOL_WORDS > 1) ? $clog2(POOL_WORDS) : 1;

   bcfg_boot_type boot_reg;
   logic [4:0] pins;
   logic [15:0] det_cnt_reg;
   logic [15:0] cmd_reg;
   logic [15:0] pool_reg [POOL_WORDS];
   logic exec_reg;
   logic apply_req_reg;
   logic [15:0] load_cnt_reg;
   logic pool_hit;
   logic [PW-1:0] pool_idx;
   logic [14:0] result;
   logic start_load;
   logic pool_wr_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // Strap pins pass the three-stage filter before the sequencer looks at them.
   bcfg_sync3 #(.W(5)) u_sync
   (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_async({i_memory_serial_in_strap, i_frame_valid, i_line_valid,
                i_low_output_bit1_pin, i_low_output_bit0_pin}),
      .o_sync(pins)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Detection waits a fixed settling time so the filtered strap is valid when sampled.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         det_cnt_reg <= '0;
      else if (boot_reg == BS_DETECT && det_cnt_reg != 16'(DETECT_CYCLES))
         det_cnt_reg <= det_cnt_reg + 16'h0001;
   end

   // Boot sequencer; reset always lands in detection.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         boot_reg <= BS_DETECT;
      else
      begin
         case (boot_reg)
            BS_DETECT:
            begin
               if (det_cnt_reg == 16'(DETECT_CYCLES))
               begin
                  if (i_mem_present)
                     boot_reg <= BS_MEMCFG;
                  else if (pins[4])
                     boot_reg <= BS_AUTOCFG;
                  else
                     boot_reg <= BS_HOSTCFG;
               end
            end
            BS_MEMCFG:
            begin
               if (!i_mem_has_records)
                  boot_reg <= BS_AUTOCFG;
               else if (i_mem_rec_done)
               begin
                  case (i_mem_rec_jump)
                     JUMP_AUTO: boot_reg <= BS_AUTOCFG;
                     JUMP_APPLY: boot_reg <= BS_APPLY;
                     default: boot_reg <= BS_HOSTCFG;
                  endcase
               end
            end
            BS_AUTOCFG:
               boot_reg <= BS_APPLY;
            BS_HOSTCFG:
            begin
               if (apply_req_reg)
                  boot_reg <= BS_APPLY;
            end
            BS_APPLY:
               boot_reg <= BS_STREAM;
            BS_STREAM:
            begin
               if (apply_req_reg)
                  boot_reg <= BS_APPLY;
            end
            default:
               boot_reg <= BS_DETECT;
         endcase
      end
   end

   // Auto setup latches format and pedestal choices from the pins.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         o_auto_setting <= '0;
      else if (boot_reg == BS_AUTOCFG)
         o_auto_setting <= pins[3:0];
   end

   // Apply commits for one cycle; streaming then holds until reset.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_apply_strobe <= 1'b0;
         o_streaming <= 1'b0;
      end
      else
      begin
         o_apply_strobe <= (boot_reg == BS_APPLY);
         if (boot_reg == BS_APPLY)
            o_streaming <= 1'b1;
      end
   end

   assign o_boot_state = boot_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode; pool writes from the host are refused while a command is pending.
   assign pool_hit = bus.addr >= POOL_OFS && bus.addr < POOL_OFS + 16'(POOL_WORDS);
   assign pool_idx = PW'(bus.addr - POOL_OFS);
   assign pool_wr_ok = bus.req && bus.we && pool_hit && !cmd_reg[DOORBELL_BIT];

   // Every request is answered one cycle later, so the host never stalls on this end.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         bus.ack <= 1'b0;
         bus.rdata <= '0;
      end
      else
      begin
         bus.ack <= bus.req;
         if (bus.req && !bus.we)
         begin
            if (bus.addr == CMD_WORD_OFS)
               bus.rdata <= cmd_reg;
            else if (pool_hit)
               bus.rdata <= pool_reg[pool_idx];
            else
               bus.rdata <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Result of the pending command, decided in its execution cycle.
   always_comb
   begin
      result = RES_OK;
      start_load = 1'b0;
      case (cmd_reg)
         CMD_SET_STATE:
            result = (pool_reg[0] == APPLY_CFG_STATE_CODE) ? RES_OK : RES_BAD_PARAM;
         CMD_GET_STATE:
            result = RES_OK;
         CMD_OVL_LOAD_BUF, CMD_OVL_LOAD_STR:
         begin
            result = o_load_busy ? RES_BUSY : RES_OK;
            start_load = !o_load_busy;
         end
         default:
         begin
            if (cmd_reg < CMD_OVL_FIRST || cmd_reg > CMD_OVL_LOAD_STR)
               result = RES_BAD_CMD;
         end
      endcase
   end

   // Doorbell: a bit-15 write latches the code; execution clears the flag next cycle.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cmd_reg <= '0;
         exec_reg <= 1'b0;
         o_doorbell_irq <= 1'b0;
         apply_req_reg <= 1'b0;
      end
      else
      begin
         o_doorbell_irq <= 1'b0;
         apply_req_reg <= 1'b0;
         exec_reg <= 1'b0;
         if (exec_reg)
         begin
            cmd_reg <= {1'b0, result};
            apply_req_reg <= cmd_reg == CMD_SET_STATE && result == RES_OK;
         end
         else if (bus.req && bus.we && bus.addr == CMD_WORD_OFS && !cmd_reg[DOORBELL_BIT]
                  && bus.wdata[DOORBELL_BIT])
         begin
            cmd_reg <= bus.wdata;
            exec_reg <= 1'b1;
            o_doorbell_irq <= 1'b1;
         end
      end
   end

   // Asynchronous overlay load keeps running after its doorbell has cleared.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         load_cnt_reg <= '0;
      else if (exec_reg && start_load)
         load_cnt_reg <= 16'(LOAD_CYCLES);
      else if (load_cnt_reg != 16'h0000)
         load_cnt_reg <= load_cnt_reg - 16'h0001;
   end

   assign o_load_busy = load_cnt_reg != 16'h0000;

   // Pool: host writes when idle, response words written in the execution cycle.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         for (int i = 0; i < POOL_WORDS; i++)
            pool_reg[i] <= '0;
      end
      else if (exec_reg && cmd_reg == CMD_GET_STATE)
         pool_reg[0] <= 16'(boot_reg);
      else if (exec_reg && cmd_reg == CMD_OVL_LOAD_STAT)
         pool_reg[0] <= load_cnt_reg;
      else if (pool_wr_ok)
         pool_reg[pool_idx] <= bus.wdata;
   end
endmodule // bcfg_device

// >>> hdl/bcfg_pkg.sv
// Constants shared by both ends of the boot and host command port.
// Assumes a single 250 MHz system clock on both ends.
package bcfg_pkg;
   localparam int CLK_MHZ = 250;
   localparam int LINK_KHZ = 400;
   localparam int LINK_GAP_CYC = (CLK_MHZ * 1000 + LINK_KHZ - 1) / LINK_KHZ;
   localparam logic [15:0] CMD_WORD_OFS = 16'h0040;
   localparam logic [15:0] POOL_OFS = 16'hFC00;
   localparam int DOORBELL_BIT = 15;
   localparam logic [15:0] CMD_SET_STATE = 16'h8100;
   localparam logic [15:0] CMD_GET_STATE = 16'h8101;
   localparam logic [15:0] CMD_OVL_FIRST = 16'h8200;
   localparam logic [15:0] CMD_OVL_LOAD_BUF = 16'h8206;
   localparam logic [15:0] CMD_OVL_LOAD_STAT = 16'h8207;
   localparam logic [15:0] CMD_OVL_LOAD_STR = 16'h820E;
   localparam logic [15:0] APPLY_CFG_STATE_CODE = 16'h2800;
   localparam logic [14:0] RES_OK = 15'h0000;
   localparam logic [14:0] RES_BUSY = 15'h0003;
   localparam logic [14:0] RES_BAD_PARAM = 15'h0006;
   localparam logic [14:0] RES_BAD_CMD = 15'h0009;
   localparam logic [1:0] JUMP_HOST = 2'h0;
   localparam logic [1:0] JUMP_AUTO = 2'h1;
   localparam logic [1:0] JUMP_APPLY = 2'h2;
   localparam logic [7:0] AXI_PARAM_OFS = 8'h00;
   localparam logic [7:0] AXI_CMD_OFS = 8'h04;
   localparam logic [7:0] AXI_STATUS_OFS = 8'h08;
   localparam logic [7:0] AXI_RESP_OFS = 8'h0C;
   localparam int AXI_SEND_PARAM_BIT = 16;
   typedef enum {BS_DETECT, BS_MEMCFG, BS_AUTOCFG, BS_HOSTCFG, BS_APPLY, BS_STREAM} bcfg_boot_type;
endpackage

// >>> hdl/bcfg_if.sv
// Register bus between the external host and the device's command port.
// One request is a single-cycle strobe; the device answers with ack.
`timescale 1ns/10ps
interface bcfg_if;
   logic req;
   logic we;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic ack;
   logic [15:0] rdata;
   modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface

// >>> hdl/bcfg_sync3.sv
// Three-stage pin synchroniser; an output bit follows once stages two and three agree.
// Assumes inputs are asynchronous to i_clk_sys.
`timescale 1ns/10ps
module bcfg_sync3 #(parameter int W = 1)
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Pins in, filtered levels out.
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // A zero-width filter has nothing to carry.
   if (W < 1)
   begin : g_bad_width
      $error("bcfg_sync3: W must be at least 1");
   end

   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end
      else
      begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Each bit changes only when two settled stages agree.
   for (genvar b = 0; b < W; b++)
   begin : g_bit
      always_ff @(posedge i_clk_sys or negedge i_resetn)
      begin
         if (!i_resetn)
            o_sync[b] <= 1'b0;
         else if (s2_reg[b] == s3_reg[b])
            o_sync[b] <= s3_reg[b];
      end
   end
endmodule // bcfg_sync3

// >>> hdl/bcfg_host.sv
// Host end: runs one command sequence on the register bus per software order.
// Assumes software drives the AXI4-Lite slave; one read and one write at a time.
`timescale 1ns/10ps
module bcfg_host
   import bcfg_pkg::*;
#(
   parameter int GAP_CYCLES = LINK_GAP_CYC
)
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // AXI4-Lite slave.
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Register bus toward the device.
   bcfg_if.host bus
);
   import bcfg_pkg::*;

   if (GAP_CYCLES < 1 || GAP_CYCLES > 65535)
   begin : g_bad_gap
      $error("bcfg_host: unsupported GAP_CYCLES");
   end

   typedef enum {HS_IDLE, HS_PARAM, HS_CMD, HS_POLL, HS_RESP} bcfg_hseq_type;
   bcfg_hseq_type seq_reg;
   logic aw_reg, w_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [15:0] param_reg, code_reg, result_reg, resp_reg;
   logic done_reg, wait_reg;
   logic [15:0] gap_reg;
   logic launch;

   ////////////////////////////////////////////////////////////////////////////////
   // Address and data are taken in either order; the response follows both.
   assign o_awready = !aw_reg && !o_bvalid;
   assign o_wready = !w_reg && !o_bvalid;
   assign o_arready = !o_rvalid;
   assign launch = aw_reg && w_reg && !o_bvalid && awaddr_reg == AXI_CMD_OFS && seq_reg == HS_IDLE;

   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         aw_reg <= 1'b0;
         w_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         o_bvalid <= 1'b0;
         o_bresp <= 2'h0;
         param_reg <= '0;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_reg <= 1'b1;
            awaddr_reg <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_reg <= 1'b1;
            wdata_reg <= i_wdata;
         end
         if (aw_reg && w_reg && !o_bvalid)
         begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            o_bvalid <= 1'b1;
            // A command order while busy is refused with SLVERR, as is an unmapped write.
            o_bresp <= (awaddr_reg == AXI_PARAM_OFS || launch) ? 2'h0 : 2'h2;
            if (awaddr_reg == AXI_PARAM_OFS && i_wstrb != 4'h0)
               param_reg <= wdata_reg[15:0];
         end
         else if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
      end
   end

   // Reads answer the cycle after the address is taken.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= 2'h0;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rresp <= 2'h0;
         case (i_araddr)
            AXI_PARAM_OFS: o_rdata <= {16'h0000, param_reg};
            AXI_STATUS_OFS: o_rdata <= {result_reg, 14'h0000, done_reg, seq_reg != HS_IDLE};
            AXI_RESP_OFS: o_rdata <= {16'h0000, resp_reg};
            default:
            begin
               o_rdata <= '0;
               o_rresp <= 2'h2;
            end
         endcase
      end
      else if (o_rvalid && i_rready)
         o_rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Requests are spaced by one link bit period so the link never runs above 400 kHz.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         gap_reg <= '0;
      else if (bus.ack)
         gap_reg <= 16'(GAP_CYCLES);
      else if (gap_reg != 16'h0000)
         gap_reg <= gap_reg - 16'h0001;
   end

   // Sequence: parameter if ordered, command, poll doorbell, fetch response word.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         seq_reg <= HS_IDLE;
         code_reg <= '0;
         result_reg <= '0;
         resp_reg <= '0;
         done_reg <= 1'b0;
         wait_reg <= 1'b0;
         bus.req <= 1'b0;
         bus.we <= 1'b0;
         bus.addr <= '0;
         bus.wdata <= '0;
      end
      else
      begin
         bus.req <= 1'b0;
         if (launch)
         begin
            code_reg <= wdata_reg[15:0];
            done_reg <= 1'b0;
            seq_reg <= wdata_reg[AXI_SEND_PARAM_BIT] ? HS_PARAM : HS_CMD;
         end
         else if (seq_reg != HS_IDLE && !wait_reg && gap_reg == 16'h0000)
         begin
            bus.req <= 1'b1;
            wait_reg <= 1'b1;
            bus.we <= seq_reg == HS_PARAM || seq_reg == HS_CMD;
            bus.addr <= (seq_reg == HS_PARAM || seq_reg == HS_RESP) ? POOL_OFS : CMD_WORD_OFS;
            bus.wdata <= (seq_reg == HS_PARAM) ? param_reg : code_reg;
         end
         else if (wait_reg && bus.ack)
         begin
            wait_reg <= 1'b0;
            case (seq_reg)
               HS_PARAM: seq_reg <= HS_CMD;
               HS_CMD: seq_reg <= HS_POLL;
               HS_POLL:
               begin
                  // No new order is accepted until the doorbell reads clear.
                  if (!bus.rdata[DOORBELL_BIT])
                  begin
                     result_reg <= bus.rdata;
                     seq_reg <= HS_RESP;
                  end
               end
               HS_RESP:
               begin
                  resp_reg <= bus.rdata;
                  done_reg <= 1'b1;
                  seq_reg <= HS_IDLE;
               end
               default: seq_reg <= HS_IDLE;
            endcase
         end
      end
   end
endmodule // bcfg_host

// >>> tb/bcfg_asserts.sv
// Checker for the word-level register bus joining the host and device ends.
// Assumes the host end spaces requests and loads the parameter before a set-state command.
`timescale 1ns/10ps
module bcfg_asserts
   import bcfg_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // Bus signals as seen on the wire.
   input wire logic req,
   input wire logic we,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [15:0] rdata
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_resetn);
   logic rd_cmd_reg;
   logic pend_reg;
   logic param_reg;
   ////////////////////////////////////////////////////////////////////////
   // Pending state is rebuilt from the wire, so a host that skips its poll is caught.
   always_ff @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rd_cmd_reg <= 1'b0;
         pend_reg <= 1'b0;
         param_reg <= 1'b0;
      end
      else
      begin
         rd_cmd_reg <= req && !we && addr == CMD_WORD_OFS;
         if (req && we && addr == CMD_WORD_OFS)
            pend_reg <= 1'b1;
         else if (ack && rd_cmd_reg && !rdata[DOORBELL_BIT])
            pend_reg <= 1'b0;
         if (req && we && addr == POOL_OFS)
            param_reg <= 1'b1;
         else if (req && we && addr == CMD_WORD_OFS)
            param_reg <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_ack_after_req: assert property (req |=> ack) else $error("ack missing after request");
   a_ack_has_cause: assert property (ack |-> $past(req)) else $error("ack without request");
   a_req_one_cycle: assert property (req |=> !req) else $error("requests too close");
   a_cmd_bit_set: assert property (req && we && addr == CMD_WORD_OFS |-> wdata[DOORBELL_BIT])
      else $error("command without doorbell bit");
   // Only set-state takes a parameter, so only it must find one loaded first.
   a_param_before_cmd: assert property (req && we && addr == CMD_WORD_OFS && wdata == CMD_SET_STATE
      |-> param_reg) else $error("command before parameter");
   a_no_write_pending: assert property (req && we && (addr == CMD_WORD_OFS || addr == POOL_OFS)
      |-> !pend_reg) else $error("write while command pending");
   a_poll_sees_clear: assert property (ack && rd_cmd_reg |-> !rdata[DOORBELL_BIT])
      else $error("doorbell not cleared");
   a_rdata_read_only: assert property (!$stable(rdata) |-> ack && !$past(we))
      else $error("read data moved without read");
endmodule // bcfg_asserts

// >>> tb/boot_config_and_host_command_port_tb.sv
// Testbench joining host and device ends; software orders go in over AXI4-Lite.
// Assumes short counts: detect 8, load 200, request gap 2 cycles.
`timescale 1ns/10ps
module boot_config_and_host_command_port_tb;
   import bcfg_pkg::*;
   logic i_clk_sys = 0, i_resetn = 0, mp = 0, mr = 0, s = 0;
   logic [1:0] mj = 0;
   logic [3:0] pl = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdat, r;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, apply, stream, irq, busy;
   logic [1:0] bresp, rresp;
   logic [3:0] auto_set;
   bcfg_boot_type bstate;
   int miscompares = 0, checks_done = 0, irq_cnt = 0, apply_cnt = 0, k;
   bcfg_if link();
   ////////////////////////////////////////////////////////////////////////
   // Clock at 250 MHz.
   always #2 i_clk_sys = ~i_clk_sys;
   // Pulse counters; apply_cnt is cleared by reset so each boot is judged alone.
   always @(posedge i_clk_sys or negedge i_resetn)
   begin
      if (!i_resetn)
         apply_cnt <= 0;
      else
      begin
         apply_cnt <= apply_cnt + int'(apply === 1'b1);
         irq_cnt <= irq_cnt + int'(irq === 1'b1);
      end
   end
   bcfg_device #(.DETECT_CYCLES(8), .LOAD_CYCLES(200)) u_bcfg_device (.i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn), .bus(link), .i_mem_present(mp), .i_mem_has_records(mr), .i_mem_rec_done(mr),
      .i_mem_rec_jump(mj), .i_memory_serial_in_strap(s), .i_frame_valid(pl[3]), .i_line_valid(pl[2]),
      .i_low_output_bit0_pin(pl[0]), .i_low_output_bit1_pin(pl[1]), .o_boot_state(bstate),
      .o_auto_setting(auto_set), .o_apply_strobe(apply), .o_streaming(stream), .o_doorbell_irq(irq),
      .o_load_busy(busy));
   bcfg_host #(.GAP_CYCLES(2)) u_bcfg_host (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .bus(link));
   bcfg_asserts u_bcfg_asserts (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .req(link.req), .we(link.we),
      .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run.
   task test_done;
   begin
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
   begin
      checks_done++;
      if (g !== x)
      begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, g, x);
      end
   end
   endtask
   // A wait that runs out ends the run as a failure.
   task limit(input int n);
   begin
      if (n >= 300)
      begin
         miscompares++;
         test_done;
      end
   end
   endtask
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
   begin
      @(posedge i_clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 300; n++)
      begin
         @(posedge i_clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      limit(n);
      chk(bresp, e);
      bready <= 1'b0;
   end
   endtask
   task axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
      int n;
   begin
      @(posedge i_clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 300; n++)
      begin
         @(posedge i_clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      limit(n);
      d = rdat;
      chk(rresp, e);
      rready <= 1'b0;
   end
   endtask
   // Polls the host status until the sequence reports done and idle.
   task wait_done(output logic [31:0] st);
      int n;
   begin
      st = 0;
      for (n = 0; n < 300 && st[1:0] !== 2'b10; n++)
         axi_rd(AXI_STATUS_OFS, st, 2'b00);
      limit(n);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // One boot under given memory and strap conditions, judged at its end state.
   task boot(input logic m, rec, input logic [1:0] j, input logic st, input logic [3:0] p, input bcfg_boot_type e,
      input logic a);
      int n;
   begin
      @(posedge i_clk_sys);
      pl <= p;
      mp <= m;
      mr <= rec;
      mj <= j;
      s <= st;
      i_resetn <= 1'b0;
      repeat (20) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      @(posedge i_clk_sys);
      #1 chk(32'(bstate), 32'(BS_DETECT));
      for (n = 0; n < 300 && bstate !== e; n++) @(posedge i_clk_sys);
      limit(n);
      repeat (5) @(posedge i_clk_sys);
      #1 chk(32'(bstate), 32'(e));
      chk(stream, e == BS_STREAM);
      chk(apply_cnt, e == BS_STREAM);
      if (a) chk(auto_set, p);
      $display("boot test done");
   end
   endtask
   // One command through the host sequence; the result and doorbell are judged.
   task cmd(input logic [15:0] p, input logic [15:0] c, input logic [14:0] res);
      int i0;
      logic [31:0] st;
   begin
      i0 = irq_cnt;
      axi_wr(AXI_PARAM_OFS, {16'h0000, p}, 2'b00);
      axi_wr(AXI_CMD_OFS, {16'h0001, c}, 2'b00);
      wait_done(st);
      chk(st[31:16], {1'b0, res});
      chk(irq_cnt, i0 + 1);
      axi_rd(AXI_RESP_OFS, r, 2'b00);
      $display("command test done");
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial
   begin
      boot(0, 0, 2'h0, 1, 4'hA, BS_STREAM, 1);
      boot(1, 0, 2'h0, 0, 4'h5, BS_STREAM, 1);
      boot(1, 1, 2'h1, 0, 4'h3, BS_STREAM, 1);
      boot(1, 1, 2'h2, 0, 4'hC, BS_STREAM, 0);
      boot(1, 1, 2'h0, 1, 4'h6, BS_HOSTCFG, 0);
      boot(0, 0, 2'h0, 0, 4'h9, BS_HOSTCFG, 0);
      cmd(16'h0000, CMD_SET_STATE, RES_BAD_PARAM);
      chk(32'(bstate), 32'(BS_HOSTCFG));
      cmd(APPLY_CFG_STATE_CODE, CMD_SET_STATE, RES_OK);
      chk(stream, 1'b1);
      cmd(16'h0000, CMD_GET_STATE, RES_OK);
      chk(r, 32'(BS_STREAM));
      cmd(16'h0000, CMD_OVL_LOAD_BUF, RES_OK);
      chk(busy, 1'b1);
      cmd(16'h0000, CMD_OVL_LOAD_STR, RES_BUSY);
      cmd(16'h0000, CMD_OVL_LOAD_STAT, RES_OK);
      chk(r != 0 && r < 200, 1'b1);
      for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge i_clk_sys);
      limit(k);
      for (k = 0; k < 15; k++)
         if (k != 6 && k != 7 && k != 14) cmd(16'h0000, CMD_OVL_FIRST + 16'(k), RES_OK);
      cmd(16'h0000, 16'h8300, RES_BAD_CMD);
      axi_wr(8'h10, 32'h0, 2'b10);
      axi_rd(8'h14, r, 2'b10);
      chk(r, 32'h0);
      axi_wr(AXI_CMD_OFS, {16'h0000, CMD_GET_STATE}, 2'b00);
      axi_wr(AXI_CMD_OFS, {16'h0001, CMD_GET_STATE}, 2'b10);
      wait_done(r);
      chk(r[31:16], {1'b0, RES_OK});
      $display("refusal test done");
      test_done;
   end
endmodule // boot_config_and_host_command_port_tb
